/* File: bench/tb_bcc_top.sv */
// Self-checking bench for the buck converter clock and pulse control.
// Assumes bcc_top with a zero-wait AHB-Lite slave and inputs sampled on clk.
`timescale 1ns/1ps
`include "bcc_cfg.svh"
module tb_bcc_top;
    logic        clk, resetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  pulseWidthReq;
    logic        localOscIn, sysClkIn, adcFreeClkIn;
    logic        convClk, switchPulse, adcSarClk, adcTrack;
    logic        prevConv, prevFree, pol;
    int          failCount, nTests, cyc;
    int          rises, highs, pulseHigh, sarBad, freeBad, overlap, trackHigh;
    // Source cases: local with divider set, then system clock variants
    logic [7:0]  srcCtrl [6] = '{8'h60, 8'h80, 8'h88, 8'ha0, 8'hc0, 8'he0};
    int          srcRise [6] = '{40, 60, 60, 30, 30, 8};
    int          srcHigh [6] = '{120, 60, 180, 120, 120, 120};
    // Pulse cases: width field, requested width, expected skip
    logic [1:0]  pwMode [6] = '{2'b00, 2'b01, 2'b10, 2'b10, 2'b11, 2'b11};
    int          pwN    [6] = '{1, 1, 1, 2, 3, 4};
    logic        pwSkip [6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};

    assign hready = hreadyout;

    bcc_top #(.PW_WIDTH(8)) dut
    (
        .clk           (clk),
        .resetn        (resetn),
        .hsel          (hsel),
        .haddr         (haddr),
        .htrans        (htrans),
        .hwrite        (hwrite),
        .hsize         (hsize),
        .hwdata        (hwdata),
        .hready        (hready),
        .hreadyout     (hreadyout),
        .hresp         (hresp),
        .hrdata        (hrdata),
        .localOscIn    (localOscIn),
        .sysClkIn      (sysClkIn),
        .pulseWidthReq (pulseWidthReq),
        .convClk       (convClk),
        .switchPulse   (switchPulse),
        .adcFreeClkIn  (adcFreeClkIn),
        .adcSarClk     (adcSarClk),
        .adcTrack      (adcTrack)
    );

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Uneven duty on the system path so inversion shows in the high time
    always @(posedge clk)
    begin
        cyc          <= cyc + 1;
        sysClkIn     <= (cyc % 4 == 0);
        localOscIn   <= (cyc % 6 < 3);
        adcFreeClkIn <= (cyc % 5 == 0);
        if (cyc == 20000)
        begin
            failCount++;
            give_verdict();
        end
    end

    // Sampled mid-cycle, away from the edge that updates the outputs
    always @(negedge clk)
    begin
        rises     += (convClk === 1'b1 && prevConv === 1'b0);
        highs     += (convClk === 1'b1);
        pulseHigh += (switchPulse === 1'b1);
        sarBad    += (adcSarClk !== (convClk ^ ~pol));
        freeBad   += (adcSarClk !== prevFree);
        overlap   += (adcTrack === 1'b1 && switchPulse !== 1'b0);
        trackHigh += (adcTrack === 1'b1);
        prevConv = convClk;
        prevFree = adcFreeClkIn;
    end

    task check(input string name, input logic [31:0] exp, input logic [31:0] got);
        nTests++;
        if (got !== exp)
        begin
            $display("ERROR %s expected %h seen %h", name, exp, got);
            failCount++;
        end
    endtask : check

    task inRange(input string name, input int v, input int lo, input int hi);
        nTests++;
        if (v < lo || v > hi)
        begin
            $display("ERROR %s expected %0d..%0d seen %0d", name, lo, hi, v);
            failCount++;
        end
    endtask : inRange

    // No wait limit here; only the cycle ceiling ends a hung transfer
    task waitReady;
        @(posedge clk);
        while (hreadyout !== 1'b1)
            @(posedge clk);
    endtask : waitReady

    task bus(input logic wr, input logic [31:0] addr, input logic [31:0] wdata);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= addr;
        htrans <= 2'b10;
        hwrite <= wr;
        hsize  <= 3'b010;
        waitReady();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wdata;
        waitReady();
        rd = hrdata;
        check("hresp okay", 32'h0, {31'h0, hresp});
    endtask : bus

    // Settling covers a full divide-by-8 period before the switch lands
    task setCtrl(input logic [7:0] v);
        bus(1'b1, `BCC_CTRL_ADDR, {24'h000000, v});
        pol = v[4];
        repeat (40) @(posedge clk);
    endtask : setCtrl

    task measure;
        @(posedge clk);
        rises = 0;
        highs = 0;
        pulseHigh = 0;
        sarBad = 0;
        freeBad = 0;
        overlap = 0;
        trackHigh = 0;
        repeat (240) @(posedge clk);
    endtask : measure

    task give_verdict;
        $display("counts: %0d checks, %0d mismatches", nTests, failCount);
        if (failCount == 0 && nTests > 0)
        begin
            $display("Regression OK");
        end
        else
        begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict

    initial
    begin
        {resetn, hsel, hwrite, htrans, haddr, hwdata, pol} = '0;
        {localOscIn, sysClkIn, adcFreeClkIn, prevConv, prevFree} = '0;
        hsize = 3'b010;
        pulseWidthReq = 8'h01;
        {cyc, failCount, nTests} = '0;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        bus(1'b0, `BCC_CTRL_ADDR, 32'h0);
        check("ctrl reset", 32'h00000003, rd);
        bus(1'b0, `BCC_STAT_ADDR, 32'h0);
        check("status source", 32'h0, {31'h0, rd[0]});
        bus(1'b1, 32'h00000100, 32'h000000ff);
        bus(1'b0, 32'h00000100, 32'h0);
        check("unmapped", 32'h0, rd);
        bus(1'b1, `BCC_CTRL_ADDR, 32'hffffffa5);
        bus(1'b0, `BCC_CTRL_ADDR, 32'h0);
        check("ctrl readback", 32'h000000a5, rd);
        $display("test registers done");

        for (int i = 0; i < 6; i++)
        begin
            setCtrl(srcCtrl[i]);
            measure();
            inRange("conv rises", rises, srcRise[i] - 1, srcRise[i] + 1);
            inRange("conv high", highs, srcHigh[i] - 16, srcHigh[i] + 16);
        end
        bus(1'b0, `BCC_STAT_ADDR, 32'h0);
        check("status system", 32'h00000001, rd);
        $display("test clock source done");

        // Polarity toggled with sync on and off
        pulseWidthReq <= 8'h02;
        for (int i = 0; i < 4; i++)
        begin
            setCtrl({3'b000, i[0], 1'b0, i[1], 2'b00});
            measure();
            if (i[1])
            begin
                check("sar follows conv", 32'h0, sarBad);
                check("track in pulse", 32'h0, overlap);
                inRange("track seen", trackHigh, 1, 240);
            end
            else
            begin
                check("sar free clock", 32'h0, freeBad);
                check("track off", 32'h0, trackHigh);
            end
        end
        $display("test adc sync done");

        // Requests at each minimum width, and just below the B and C minimum widths
        for (int i = 0; i < 6; i++)
        begin
            pulseWidthReq <= pwN[i][7:0];
            setCtrl({6'b000000, pwMode[i]});
            measure();
            if (pwSkip[i])
            begin
                check("pulse skipped", 32'h0, pulseHigh);
            end
            else
            begin
                inRange("pulse high", pulseHigh, (rises - 1) * pwN[i], (rises + 1) * pwN[i]);
            end
            bus(1'b0, `BCC_STAT_ADDR, 32'h0);
            check("status skip", pwSkip[i] ? 32'h4 : 32'h0, rd);
        end
        $display("test pulse width done");
        give_verdict();
    end
endmodule : tb_bcc_top

/* File: rtl/bcc_cfg.svh */
// Constants for the buck converter clock and pulse control block.
// Assumes a 100 MHz system clock and a 32-bit AHB-Lite register bus.
`ifndef BCC_CFG_SVH
`define BCC_CFG_SVH

// Register indices; byte address is four times the index
`define BCC_CTRL_INDEX      8'h97
`define BCC_STAT_INDEX      8'h98
`define BCC_CTRL_ADDR       ({22'h000000, `BCC_CTRL_INDEX, 2'b00})
`define BCC_STAT_ADDR       ({22'h000000, `BCC_STAT_INDEX, 2'b00})

// Control register fields
`define BCC_SRC_BIT         7
`define BCC_DIV_MSB         6
`define BCC_DIV_LSB         5
`define BCC_ADCPOL_BIT      4
`define BCC_INV_BIT         3
`define BCC_SYNC_BIT        2
`define BCC_MINPULSE_MSB    1
`define BCC_MINPULSE_LSB    0
`define BCC_CTRL_RESET      8'h03

// Status register fields
`define BCC_STAT_SRC_BIT    0
`define BCC_STAT_BUSY_BIT   1
`define BCC_STAT_SKIP_BIT   2

// Timing
`define BCC_CLK_PERIOD_NS   10
`define BCC_MINPULSE_A_NS   10
`define BCC_MINPULSE_B_NS   20
`define BCC_MINPULSE_C_NS   40
`define BCC_NS_TO_CYC(ns)   (((ns) + `BCC_CLK_PERIOD_NS - 1) / `BCC_CLK_PERIOD_NS)
`define BCC_MINPULSE_A_CYC  `BCC_NS_TO_CYC(`BCC_MINPULSE_A_NS)
`define BCC_MINPULSE_B_CYC  `BCC_NS_TO_CYC(`BCC_MINPULSE_B_NS)
`define BCC_MINPULSE_C_CYC  `BCC_NS_TO_CYC(`BCC_MINPULSE_C_NS)

`endif

/* File: rtl/bcc_clk_path.sv */
// Converter clock source mux, input inversion and divider.
// Assumes sysClkIn and localOscIn are sampled levels synchronous to clk.
`timescale 1ns/1ps
module bcc_clk_path
    import bcc_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // Clock sources
    input  wire logic       localOscIn,
    input  wire logic       sysClkIn,
    // Active settings
    input  wire logic       sourceSel,
    input  wire bcc_div_t   divSel,
    input  wire logic       invertIn,
    input  wire logic       restart,
    // Result
    output logic            pathLevel
);

    logic       srcLevel;
    logic       prevLevel;
    logic [2:0] riseCount;
    logic       divLevel;

    assign srcLevel = sysClkIn ^ invertIn;

    // Counter restarts at zero so a fresh divided clock begins low
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            prevLevel <= 1'b0;
            riseCount <= 3'h0;
        end
        else if (restart)
        begin
            prevLevel <= srcLevel;
            riseCount <= 3'h0;
        end
        else
        begin
            prevLevel <= srcLevel;
            if (srcLevel && !prevLevel)
                riseCount <= riseCount + 3'h1;
        end
    end

    always_comb
    begin
        case (divSel)
            BCC_DIV_1:  divLevel = srcLevel;
            BCC_DIV_2A: divLevel = riseCount[0];
            BCC_DIV_2B: divLevel = riseCount[0];
            BCC_DIV_8:  divLevel = riseCount[2];
            default:    divLevel = srcLevel;
        endcase
    end

    assign pathLevel = sourceSel ? divLevel : localOscIn;

    div_count_a: assert property (@(posedge clk) disable iff (!resetn)
        (!restart && srcLevel && !prevLevel) |=> riseCount == $past(riseCount) + 3'h1)
        else $error("divider count did not step on input rise");

endmodule : bcc_clk_path

/* File: rtl/bcc_pkg.sv */
// Types for the buck converter clock and pulse control block.
// Constants live in bcc_cfg.svh.
package bcc_pkg;

    typedef enum logic [1:0]
    {
        BCC_RUN  = 2'b00,
        BCC_PARK = 2'b01,
        BCC_ARM  = 2'b11
    } bcc_state_t;

    typedef enum logic [1:0]
    {
        BCC_DIV_1  = 2'b00,
        BCC_DIV_2A = 2'b01,
        BCC_DIV_2B = 2'b10,
        BCC_DIV_8  = 2'b11
    } bcc_div_t;

    typedef enum logic [1:0]
    {
        BCC_MINPULSE_OFF = 2'b00,
        BCC_MINPULSE_A   = 2'b01,
        BCC_MINPULSE_B   = 2'b10,
        BCC_MINPULSE_C   = 2'b11
    } bcc_minpulse_t;

endpackage : bcc_pkg

/* File: rtl/bcc_top.sv */
// Buck converter clock and pulse control: register, clock switch,
// pulse width and skipping, ADC alignment.
// Assumes an AHB-Lite master and inputs synchronous to clk.
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "bcc_cfg.svh"
module bcc_top
    import bcc_pkg::*;
#(
    parameter int PW_WIDTH = 8
)
(
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                resetn,
    // AHB-Lite slave
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic                     hresp,
    output logic [31:0]              hrdata,
    // Converter clock sources and regulation request
    input  wire logic                localOscIn,
    input  wire logic                sysClkIn,
    input  wire logic [PW_WIDTH-1:0] pulseWidthReq,
    // Converter drive
    output logic                     convClk,
    output logic                     switchPulse,
    // ADC alignment
    input  wire logic                adcFreeClkIn,
    output logic                     adcSarClk,
    output logic                     adcTrack
);

    logic [7:0]          ctrl;
    logic                activeSel;
    bcc_div_t            activeDiv;
    logic                activeInv;
    bcc_state_t          state;
    bcc_state_t          next_state;
    logic                pathLevel;
    logic                dividerRestart;
    logic                cfgDiffers;
    logic                next_convClk;
    logic                convRise;
    logic [PW_WIDTH-1:0] pulseLeft;
    logic [PW_WIDTH-1:0] minCycles;
    logic                minOn;
    logic                skipNow;
    logic                next_switchPulse;
    logic                lastSkipped;
    logic                addrTake;
    logic                dataWrite;
    logic [31:0]         dataAddr;
    logic [7:0]          ctrlView;
    logic [7:0]          statusView;
    logic                syncEn;
    logic                adcPolarity;

    assign syncEn      = ctrl[`BCC_SYNC_BIT];
    assign adcPolarity = ctrl[`BCC_ADCPOL_BIT];

    // Bus slave: zero wait states, always OKAY
    assign addrTake = hsel && htrans[1] && hready;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            dataWrite <= 1'b0;
            dataAddr  <= 32'h00000000;
        end
        else
        begin
            dataWrite <= addrTake && hwrite;
            if (addrTake)
                dataAddr <= haddr;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Control register; unmapped writes are dropped
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            ctrl <= `BCC_CTRL_RESET;
        else if (dataWrite && dataAddr == `BCC_CTRL_ADDR)
            ctrl <= hwdata[7:0];
    end

    // Forward a write still in its data phase so back-to-back reads see it
    assign ctrlView = (dataWrite && dataAddr == `BCC_CTRL_ADDR) ? hwdata[7:0] : ctrl;

    always_comb
    begin
        statusView = 8'h00;
        statusView[`BCC_STAT_SRC_BIT]  = activeSel;
        statusView[`BCC_STAT_BUSY_BIT] = (state != BCC_RUN);
        statusView[`BCC_STAT_SKIP_BIT] = lastSkipped;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            hrdata <= 32'h00000000;
        else if (addrTake && !hwrite)
        begin
            if (haddr == `BCC_CTRL_ADDR)
                hrdata <= {24'h000000, ctrlView};
            else if (haddr == `BCC_STAT_ADDR)
                hrdata <= {24'h000000, statusView};
            else
                hrdata <= 32'h00000000;
        end
        else
            hrdata <= 32'h00000000;
    end

    // Clock path
    bcc_clk_path u_path
    (
        .clk        (clk),
        .resetn     (resetn),
        .localOscIn (localOscIn),
        .sysClkIn   (sysClkIn),
        .sourceSel  (activeSel),
        .divSel     (activeDiv),
        .invertIn   (activeInv),
        .restart    (dividerRestart),
        .pathLevel  (pathLevel)
    );

    // Divider and inversion only matter on the system clock path
    assign cfgDiffers = (ctrl[`BCC_SRC_BIT] != activeSel) ||
                        (ctrl[`BCC_SRC_BIT] &&
                         ((ctrl[`BCC_DIV_MSB:`BCC_DIV_LSB] != activeDiv) ||
                          (ctrl[`BCC_INV_BIT] != activeInv)));

    // Switch only while the old clock is low, resume once the new one is
    // low, so no high phase is ever cut short
    always_comb
    begin
        next_state = state;
        case (state)
            BCC_RUN:  if (cfgDiffers && !pathLevel) next_state = BCC_PARK;
            BCC_PARK: next_state = BCC_ARM;
            BCC_ARM:  if (!pathLevel) next_state = BCC_RUN;
            default:  next_state = BCC_RUN;
        endcase
    end

    assign dividerRestart = (state == BCC_PARK);
    assign next_convClk   = (state == BCC_RUN) ? pathLevel : 1'b0;
    assign convRise       = next_convClk && !convClk;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            state <= BCC_PARK;
        else
            state <= next_state;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            activeSel <= 1'b0;
            activeDiv <= BCC_DIV_1;
            activeInv <= 1'b0;
        end
        else if (state == BCC_PARK)
        begin
            activeSel <= ctrl[`BCC_SRC_BIT];
            activeDiv <= bcc_div_t'(ctrl[`BCC_DIV_MSB:`BCC_DIV_LSB]);
            activeInv <= ctrl[`BCC_INV_BIT];
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            convClk <= 1'b0;
        else
            convClk <= next_convClk;
    end

    // Minimum pulse width in cycles, rounded up
    always_comb
    begin
        case (bcc_minpulse_t'(ctrl[`BCC_MINPULSE_MSB:`BCC_MINPULSE_LSB]))
            BCC_MINPULSE_OFF: minCycles = '0;
            BCC_MINPULSE_A:   minCycles = PW_WIDTH'(`BCC_MINPULSE_A_CYC);
            BCC_MINPULSE_B:   minCycles = PW_WIDTH'(`BCC_MINPULSE_B_CYC);
            BCC_MINPULSE_C:   minCycles = PW_WIDTH'(`BCC_MINPULSE_C_CYC);
            default:          minCycles = '0;
        endcase
    end

    assign minOn   = (ctrl[`BCC_MINPULSE_MSB:`BCC_MINPULSE_LSB] != BCC_MINPULSE_OFF);
    assign skipNow = convRise && minOn && (pulseWidthReq < minCycles);

    // Pulse starts on the converter clock rise and lasts the request
    always_comb
    begin
        if (convRise)
            next_switchPulse = (pulseWidthReq != '0) && !skipNow;
        else
            next_switchPulse = (pulseLeft != '0);
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            switchPulse <= 1'b0;
            pulseLeft   <= '0;
            lastSkipped <= 1'b0;
        end
        else
        begin
            switchPulse <= next_switchPulse;
            if (convRise)
            begin
                lastSkipped <= skipNow;
                if (next_switchPulse)
                    pulseLeft <= pulseWidthReq - PW_WIDTH'(1);
                else
                    pulseLeft <= '0;
            end
            else if (pulseLeft != '0)
                pulseLeft <= pulseLeft - PW_WIDTH'(1);
        end
    end

    // ADC alignment; prescale must already be zero when sync is set
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            adcTrack  <= 1'b0;
            adcSarClk <= 1'b0;
        end
        else
        begin
            adcTrack <= syncEn && !next_switchPulse;
            if (syncEn)
                adcSarClk <= next_convClk ^ !adcPolarity;
            else
                adcSarClk <= adcFreeClkIn;
        end
    end

    // Checks
    sequence pulse_start_s;
        convRise && !skipNow && pulseWidthReq == PW_WIDTH'(2);
    endsequence

    sequence pulse_two_s;
        switchPulse [*2] ##1 !switchPulse;
    endsequence

    property pulse_width_p;
        @(posedge clk) disable iff (!resetn)
        pulse_start_s |=> pulse_two_s;
    endproperty

    src_local_a: assert property (@(posedge clk) disable iff (!resetn)
        (state == BCC_RUN && !activeSel) |=> convClk == $past(localOscIn))
        else $error("converter clock does not follow local oscillator");

    div_one_a: assert property (@(posedge clk) disable iff (!resetn)
        (state == BCC_RUN && activeSel && activeDiv == BCC_DIV_1 && !activeInv)
        |=> convClk == $past(sysClkIn))
        else $error("divide by one does not pass system clock");

    ignore_div_a: assert property (@(posedge clk) disable iff (!resetn)
        !activeSel |-> pathLevel == localOscIn)
        else $error("divider affects local oscillator path");

    inv_path_a: assert property (@(posedge clk) disable iff (!resetn)
        (state == BCC_RUN && activeSel && activeDiv == BCC_DIV_1 && activeInv)
        |=> convClk != $past(sysClkIn))
        else $error("inverted system clock not inverted");

    track_quiet_a: assert property (@(posedge clk) disable iff (!resetn)
        next_switchPulse |=> !adcTrack && switchPulse)
        else $error("ADC tracking during switching pulse");

    sar_sync_a: assert property (@(posedge clk) disable iff (!resetn)
        syncEn |=> adcSarClk == (convClk ^ !$past(adcPolarity)))
        else $error("SAR clock not derived from converter clock");

    sar_free_a: assert property (@(posedge clk) disable iff (!resetn)
        !syncEn |=> adcSarClk == $past(adcFreeClkIn) && !adcTrack)
        else $error("alignment applied while sync is off");

    skip_whole_a: assert property (@(posedge clk) disable iff (!resetn)
        skipNow |=> !switchPulse && lastSkipped)
        else $error("short pulse not skipped");

    pulse_width_a: assert property (pulse_width_p)
        else $error("switching pulse width wrong");

    no_runt_a: assert property (@(posedge clk) disable iff (!resetn)
        (convClk && !next_convClk) |-> (state == BCC_RUN && !pathLevel))
        else $error("converter clock high phase cut short");

endmodule : bcc_top
